// ---- src/rtc_spi_pkg.sv ----
// Constants and types shared by the serial command interface of the clock/calendar.
package rtc_spi_pkg;

  // Instruction codes.
  localparam logic [7:0] USER_NVM_READ_CMD = 8'h03;
  localparam logic [7:0] USER_NVM_WRITE_CMD = 8'h02;
  localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] CLOCK_SPACE_READ_CMD = 8'h13;
  localparam logic [7:0] CLOCK_SPACE_WRITE_CMD = 8'h12;
  localparam logic [7:0] UNLOCK_STEP_CMD = 8'h14;
  localparam logic [7:0] PROTECTED_NVM_WRITE_CMD = 8'h32;
  localparam logic [7:0] PROTECTED_NVM_READ_CMD = 8'h33;
  localparam logic [7:0] SCRATCH_MEMORY_CLEAR_CMD = 8'h54;

  // Shared clock-register and scratch memory space.
  localparam logic [7:0] CLK_REG_LAST = 8'h1f;
  localparam logic [7:0] SRAM_FIRST = 8'h20;
  localparam logic [7:0] SRAM_LAST = 8'h5f;
  localparam int CLK_REG_BYTES = 32;
  localparam int SRAM_BYTES = 64;

  // Alarm flag bits, overlaid on the clock-register space.
  localparam logic [7:0] ALM0_FLAG_ADDR = 8'h0f;
  localparam logic [7:0] ALM1_FLAG_ADDR = 8'h16;
  localparam logic [7:0] ALM_FLAG_MASK = 8'h08;

  // Nonvolatile arrays.
  localparam int USER_NVM_BYTES_DEF = 256;
  localparam int ID_BYTES = 16;
  localparam int PAGE_BYTES = 8;
  localparam int PAGE_IDX_W = 3;
  localparam logic [7:0] NVM_ERASED = 8'hff;
  localparam logic [7:0] INVALID_READ = 8'h00;

  // Unlock keys; plain values.
  localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_B = 8'haa;

  // Status byte layout.
  localparam logic [7:0] STAT_BUSY_MASK = 8'h01;
  localparam logic [7:0] STAT_WEL_MASK = 8'h02;
  localparam int STAT_BP_LSB = 2;

  // Nonvolatile write cycle time and its cycle count at the system clock.
  localparam int TWC_MS = 5;
  localparam int SYS_CLK_MHZ = 250;
  localparam int TWC_CLKS = TWC_MS * 1000 * SYS_CLK_MHZ;

  // Link-side sequencer states and address spaces.
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_STAT_RD, ST_STAT_WR, ST_KEY, ST_IDLE
  } link_state_t;

  typedef enum logic [1:0] {SP_CLK, SP_USER, SP_ID} space_t;

endpackage

// ---- src/sync_two_stage.sv ----
// Two-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int W = 1
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic arst,
  input wire logic en,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_q <= '0;
      q <= '0;
    end else if (en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- src/rtc_spi_slave.sv ----
// Serial command interface of the clock/calendar: framing, decode, memories, write cycle.
//
// Function
// - Chip select low selects, high ignores.
// - Started write cycle finishes despite chip select.
// - Data output floats while deselected.
// - No decode before first chip-select fall.
// - Input bits captured on serial clock rise.
// - Output bits change after serial clock fall.
// - Alarm pin pulls low until flag cleared.
// - First eight bits form the instruction.
// - Everything travels most significant bit first.
// - First bit taken on first rise.
// - User nonvolatile read and write codes.
// - Write latch set and clear codes.
// - Status read and status write codes.
// - Clock and scratch space read, write.
// - Unlock step precedes protected writes.
// - Protected nonvolatile write and read codes.
// - Clear code zeroes all scratch memory.
// - Clock registers low, scratch memory above.
// - Out-of-range reads return no valid data.
// - User and protected arrays, own instructions.
// - Clock registers and scratch memory retained.
// - Write cycle starts at select rise, bounded.
`timescale 1ns/1ps
module rtc_spi_slave
  import rtc_spi_pkg::*;
#(
  parameter int USER_NVM_BYTES = USER_NVM_BYTES_DEF,
  parameter int WRITE_CYCLE_CLKS = TWC_CLKS
) (
  // System clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // Alarm events from the timekeeping logic
  input wire logic [1:0] alarm_event,
  // Open-drain alarm pin
  output logic shared_alarm_output_pin_out,
  output logic shared_alarm_output_pin_oe
);

  localparam int TMR_W = $clog2(WRITE_CYCLE_CLKS + 1);

  // Parameters the logic cannot serve are refused.
  if (USER_NVM_BYTES != 128 && USER_NVM_BYTES != 256) begin : g_bad_size
    $error("user array size must be 128 or 256 bytes");
  end
  if (WRITE_CYCLE_CLKS < 1) begin : g_bad_twc
    $error("write cycle count must be at least one");
  end

  // System-domain state.
  logic armed_q;
  logic busy_q;
  logic [TMR_W-1:0] tmr_q;
  logic commit_ack_q;
  logic [1:0] alm_q;
  logic mfp_oe_q;
  logic [7:0] user_mem [USER_NVM_BYTES];
  logic [7:0] id_mem [ID_BYTES];
  logic [3:0] sys_sync;

  // Link-domain state kept across frames.
  logic wel_q;
  logic [1:0] bp_q;
  logic [1:0] unlock_q;
  logic commit_tgl_q;
  logic [1:0] alm_clr_tgl_q;
  logic [7:0] clk_regs [CLK_REG_BYTES];
  logic [7:0] sram [SRAM_BYTES];
  logic [7:0] page_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask_q;
  logic [7-PAGE_IDX_W:0] page_base_q;
  logic page_to_id_q;

  // Link-domain state that lives for one frame; link_sync alone persists across frames.
  link_state_t state_q;
  space_t space_q;
  logic op_rd_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [7:0] addr_q;
  logic [7:0] tx_q;
  logic so_q;
  logic so_oe_q;
  logic [2:0] link_sync;

  // Synchronised views.
  wire cs_hi_s = sys_sync[0];
  wire commit_s = sys_sync[1];
  wire [1:0] alm_clr_s = sys_sync[3:2];
  wire busy_s = link_sync[0];
  wire [1:0] alm_s = link_sync[2:1];

  // power-up arming
  // Frame logic is held in reset while deselected or before the first fall.
  wire frame_rst = cs_n | ~armed_q;

  // Incoming byte and decode.
  wire [7:0] byte_in = {sh_q, si};
  wire byte_done = (bit_q == 3'h7);
  wire cmd_done = (state_q == ST_CMD) && byte_done;
  wire wdata_done = (state_q == ST_WDATA) && byte_done;
  wire [7:0] addr_inc = addr_q + 8'h01;
  wire [7:0] addr_page_inc = {addr_q[7:PAGE_IDX_W], addr_q[PAGE_IDX_W-1:0] + 3'h1};

  wire op_user_rd = (byte_in == USER_NVM_READ_CMD);
  wire op_user_wr = (byte_in == USER_NVM_WRITE_CMD);
  wire op_clk_rd = (byte_in == CLOCK_SPACE_READ_CMD);
  wire op_clk_wr = (byte_in == CLOCK_SPACE_WRITE_CMD);
  wire op_id_rd = (byte_in == PROTECTED_NVM_READ_CMD);
  wire op_id_wr = (byte_in == PROTECTED_NVM_WRITE_CMD);
  wire op_any_rd = op_user_rd | op_clk_rd | op_id_rd;

  // unlock required
  // Nonvolatile instructions are also refused while a write cycle runs.
  wire user_wr_ok = op_user_wr & wel_q & ~busy_s;
  wire id_wr_ok = op_id_wr & wel_q & ~busy_s & (unlock_q == 2'h2);
  wire nvm_rd_ok = (op_user_rd | op_id_rd) & ~busy_s;
  wire stat_wr_ok = (byte_in == STATUS_WRITE_CMD) & wel_q & ~busy_s;
  wire addr_ok = op_clk_rd | op_clk_wr | nvm_rd_ok | user_wr_ok | id_wr_ok;
  wire nvm_wr_start = cmd_done & (user_wr_ok | id_wr_ok);
  wire space_t cmd_space = (op_user_rd | op_user_wr) ? SP_USER :
                           (op_id_rd | op_id_wr) ? SP_ID : SP_CLK;

  // Block protect: lowest address that refuses user writes.
  wire [8:0] user_size = 9'(USER_NVM_BYTES);
  wire [8:0] prot_lo = (bp_q == 2'h3) ? 9'h000 :
                       (bp_q == 2'h2) ? (user_size >> 1) :
                       (bp_q == 2'h1) ? (user_size - (user_size >> 2)) : user_size;

  // space layout
  // Read multiplexer; the address is the one about to be used for the next byte.
  wire [7:0] rd_addr = (state_q == ST_ADDR) ? byte_in : addr_inc;
  wire [7:0] clk_rd = clk_regs[rd_addr[4:0]];
  wire alm_bit = (rd_addr == ALM0_FLAG_ADDR) ? alm_s[0] : alm_s[1];
  wire is_alm_addr = (rd_addr == ALM0_FLAG_ADDR) || (rd_addr == ALM1_FLAG_ADDR);
  wire [7:0] clk_rd_ov = is_alm_addr ?
                         ((clk_rd & ~ALM_FLAG_MASK) | (alm_bit ? ALM_FLAG_MASK : 8'h00)) :
                         clk_rd;
  wire [5:0] sram_rd_idx = 6'(rd_addr - SRAM_FIRST);
  wire [7:0] clk_space_rd = (rd_addr <= CLK_REG_LAST) ? clk_rd_ov :
                            (rd_addr <= SRAM_LAST) ? sram[sram_rd_idx] : INVALID_READ;
  wire [7:0] user_rd = ({1'b0, rd_addr} < user_size) ? user_mem[rd_addr] : INVALID_READ;
  wire [7:0] id_rd = (rd_addr < 8'(ID_BYTES)) ? id_mem[rd_addr[3:0]] : INVALID_READ;
  wire [7:0] rd_data = (space_q == SP_USER) ? user_rd :
                       (space_q == SP_ID) ? id_rd : clk_space_rd;
  wire [7:0] stat_byte = ({6'h00, bp_q} << STAT_BP_LSB) | (wel_q ? STAT_WEL_MASK : 8'h00) |
                         (busy_s ? STAT_BUSY_MASK : 8'h00);

  // Write-side address checks for the data byte now completing.
  wire [5:0] sram_wr_idx = 6'(addr_q - SRAM_FIRST);
  wire user_wr_in = ({1'b0, addr_q} < prot_lo);
  wire id_wr_in = (addr_q < 8'(ID_BYTES));
  wire alm0_clr = (addr_q == ALM0_FLAG_ADDR) && ((byte_in & ALM_FLAG_MASK) == 8'h00);
  wire alm1_clr = (addr_q == ALM1_FLAG_ADDR) && ((byte_in & ALM_FLAG_MASK) == 8'h00);

  // Start of a write cycle in the system domain.
  wire commit_pend = (commit_s != commit_ack_q);
  wire cycle_go = commit_pend & cs_hi_s & ~busy_q;

  // Synchronisers: chip select, commit toggle and alarm clears into the system clock.
  sync_two_stage #(.W(4)) u_sys_sync (
    .clk(clk_sys),
    .arst(rst),
    .en(ce),
    .d({alm_clr_tgl_q, commit_tgl_q, cs_n}),
    .q(sys_sync)
  );

  // Busy and alarm flags into the link clock, which only runs inside frames.
  sync_two_stage #(.W(3)) u_link_sync (
    .clk(sck),
    .arst(rst),
    .en(1'b1),
    .d({alm_q, busy_q}),
    .q(link_sync)
  );

  // power-up arming
  // Arming needs chip select seen high, so a later fall opens the first frame.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (ce && cs_hi_s) begin
      armed_q <= 1'b1;
    end
  end

  // runs to completion
  // The timer ignores chip select once started; a commit with no bytes is only acknowledged.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
      commit_ack_q <= 1'b0;
    end else if (ce) begin
      if (cycle_go) begin
        commit_ack_q <= commit_s;
        busy_q <= (page_mask_q != '0);
        tmr_q <= TMR_W'(WRITE_CYCLE_CLKS);
      end else if (busy_q) begin
        tmr_q <= tmr_q - TMR_W'(1);
        busy_q <= (tmr_q != TMR_W'(1));
      end
    end
  end

  // nonvolatile arrays
  // The page buffer is stable here: the link clock has stopped with chip select high.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < USER_NVM_BYTES; i++) begin
        user_mem[i] <= NVM_ERASED;
      end
      for (int i = 0; i < ID_BYTES; i++) begin
        id_mem[i] <= NVM_ERASED;
      end
    end else if (ce && cycle_go) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_mask_q[i] && page_to_id_q) begin
          id_mem[{page_base_q[0], 3'(i)}] <= page_data[i];
        end else if (page_mask_q[i]) begin
          user_mem[{page_base_q, 3'(i)}] <= page_data[i];
        end
      end
    end
  end

  // Clear requests arrive as toggles; a pulse is the change against the last seen value.
  logic [1:0] alm_clr_seen_q;
  wire [1:0] alm_clr_pls = alm_clr_s ^ alm_clr_seen_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alm_clr_seen_q <= 2'h0;
    end else if (ce) begin
      alm_clr_seen_q <= alm_clr_s;
    end
  end

  // alarm pin holds
  // A new alarm wins over a clear arriving in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alm_q <= 2'h0;
      mfp_oe_q <= 1'b0;
    end else if (ce) begin
      alm_q <= alarm_event | (alm_q & ~alm_clr_pls);
      mfp_oe_q <= |alm_q;
    end
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_in[6:0];
    end
  end

  // address then data
  // Per-frame sequencer; the next output byte is loaded as each command, address, read or status-read byte ends.
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      state_q <= ST_CMD;
      space_q <= SP_CLK;
      op_rd_q <= 1'b0;
      addr_q <= 8'h00;
      tx_q <= 8'h00;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
      if (byte_done) begin
        case (state_q)
          ST_CMD: begin
            space_q <= cmd_space;
            op_rd_q <= op_any_rd;
            tx_q <= stat_byte;
            if (addr_ok) begin
              state_q <= ST_ADDR;
            end else if (byte_in == STATUS_READ_CMD) begin
              state_q <= ST_STAT_RD;
            end else if (stat_wr_ok) begin
              state_q <= ST_STAT_WR;
            end else if (byte_in == UNLOCK_STEP_CMD) begin
              state_q <= ST_KEY;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          ST_ADDR: begin
            addr_q <= byte_in;
            tx_q <= rd_data;
            state_q <= op_rd_q ? ST_RDATA : ST_WDATA;
          end
          ST_RDATA: begin
            addr_q <= addr_inc;
            tx_q <= rd_data;
          end
          ST_WDATA: begin
            addr_q <= (space_q == SP_CLK) ? addr_inc : addr_page_inc;
          end
          ST_STAT_RD: begin
            tx_q <= stat_byte;
          end
          ST_STAT_WR, ST_KEY: begin
            state_q <= ST_IDLE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q <= tx_q[7];
      so_oe_q <= (state_q == ST_RDATA) || (state_q == ST_STAT_RD);
    end
  end

  // unlock keys
  // Latch, protect bits and unlock progress persist across frames.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
      bp_q <= 2'h0;
      unlock_q <= 2'h0;
    end else if (cmd_done && byte_in == WRITE_LATCH_SET_CMD) begin
      wel_q <= 1'b1;
    end else if (cmd_done && byte_in == WRITE_LATCH_CLEAR_CMD) begin
      wel_q <= 1'b0;
    end else if (nvm_wr_start) begin
      wel_q <= 1'b0;
      unlock_q <= op_id_wr ? 2'h0 : unlock_q;
    end else if (state_q == ST_STAT_WR && byte_done) begin
      bp_q <= byte_in[STAT_BP_LSB+1:STAT_BP_LSB];
      wel_q <= 1'b0;
    end else if (state_q == ST_KEY && byte_done) begin
      if (unlock_q == 2'h0 && byte_in == UNLOCK_KEY_A) begin
        unlock_q <= 2'h1;
      end else if (unlock_q == 2'h1 && byte_in == UNLOCK_KEY_B) begin
        unlock_q <= 2'h2;
      end else begin
        unlock_q <= 2'h0;
      end
    end
  end

  // retained contents
  // Volatile space; besides writes, only the system reset and the clear code touch it, never a frame boundary.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CLK_REG_BYTES; i++) begin
        clk_regs[i] <= 8'h00;
      end
      for (int i = 0; i < SRAM_BYTES; i++) begin
        sram[i] <= 8'h00;
      end
      alm_clr_tgl_q <= 2'h0;
    end else if (cmd_done && byte_in == SCRATCH_MEMORY_CLEAR_CMD) begin
      for (int i = 0; i < SRAM_BYTES; i++) begin
        sram[i] <= 8'h00;
      end
    end else if (wdata_done && space_q == SP_CLK) begin
      if (addr_q <= CLK_REG_LAST) begin
        clk_regs[addr_q[4:0]] <= byte_in;
        alm_clr_tgl_q <= alm_clr_tgl_q ^ {alm1_clr, alm0_clr};
      end else if (addr_q <= SRAM_LAST) begin
        sram[sram_wr_idx] <= byte_in;
      end
    end
  end

  // page collection
  // Bytes gather here; the cycle itself waits for chip select to rise.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_data[i] <= 8'h00;
      end
      page_mask_q <= '0;
      page_base_q <= '0;
      page_to_id_q <= 1'b0;
      commit_tgl_q <= 1'b0;
    end else if (nvm_wr_start) begin
      page_mask_q <= '0;
      page_to_id_q <= op_id_wr;
      commit_tgl_q <= ~commit_tgl_q;
    end else if (wdata_done && space_q != SP_CLK) begin
      if ((space_q == SP_USER && user_wr_in) || (space_q == SP_ID && id_wr_in)) begin
        page_data[addr_q[PAGE_IDX_W-1:0]] <= byte_in;
        page_mask_q[addr_q[PAGE_IDX_W-1:0]] <= 1'b1;
        page_base_q <= addr_q[7:PAGE_IDX_W];
      end
    end
  end

  // Data outputs and the alarm pin enable come straight from flops; the alarm pin only ever drives low.
  assign so_out = so_q;
  assign so_oe = so_oe_q;
  assign shared_alarm_output_pin_out = 1'b0;
  assign shared_alarm_output_pin_oe = mfp_oe_q;

endmodule

// ---- test/rtc_spi_slave_asserts.sv ----
// Concurrent checks on the ports of the serial command interface.
`timescale 1ns/1ps
module rtc_spi_slave_checker
  import rtc_spi_pkg::*;
(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  // Alarm events and open-drain pin
  input wire logic [1:0] alarm_event,
  input wire logic shared_alarm_output_pin_out,
  input wire logic shared_alarm_output_pin_oe
);
  logic [4:0] rise_cnt_q;
  logic [7:0] op_q;
  logic [3:0] idle_cnt_q;

  // Serial clock rises in this frame; a high select clears it at once, like the frame logic.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt_q <= 5'h00;
    end else if (rise_cnt_q != 5'h1f) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  // Instruction byte as seen on the wire, most significant bit first.
  always_ff @(posedge sck) begin
    if (rise_cnt_q < 5'h08) begin
      op_q <= {op_q[6:0], si};
    end
  end

  // System cycles since select went high, so that late flag clears are not mistaken for faults.
  always_ff @(posedge clk_sys) begin
    if (rst || !cs_n) begin
      idle_cnt_q <= 4'h0;
    end else if (idle_cnt_q != 4'hf) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end
  end

  chk_float_deselect: assert property (@(posedge clk_sys) disable iff (rst) cs_n |-> !so_oe)
    else $error("data output driven while deselected");
  chk_no_early_drive: assert property (@(posedge clk_sys) disable iff (rst) (rise_cnt_q < 5'h08) |-> !so_oe)
    else $error("data output driven during instruction byte");
  chk_status_answer: assert property (@(posedge clk_sys) disable iff (rst) (rise_cnt_q == 5'h08 && op_q == STATUS_READ_CMD && !sck && !cs_n) |-> so_oe)
    else $error("status read not answered after instruction byte");
  chk_stable_on_rise: assert property (@(posedge clk_sys) disable iff (rst) (!cs_n && $rose(sck)) |-> ($stable(so_out) && $stable(so_oe)))
    else $error("data output moved at a serial clock rise");
  chk_drive_at_fall: assert property (@(posedge clk_sys) disable iff (rst) $rose(so_oe) |-> (!cs_n && !sck))
    else $error("data output enabled outside a clock low phase");
  chk_drive_holds: assert property (@(posedge clk_sys) disable iff (rst) (!cs_n && so_oe) |=> (so_oe || cs_n))
    else $error("data output released inside a read frame");
  chk_pin_sinks_only: assert property (@(posedge clk_sys) disable iff (rst) !shared_alarm_output_pin_out)
    else $error("alarm pin driven high");
  chk_alarm_pulls: assert property (@(posedge clk_sys) disable iff (rst) (ce && alarm_event != 2'b00) ##1 ce |-> ##1 shared_alarm_output_pin_oe)
    else $error("alarm pin not pulled two cycles after an alarm");
  chk_alarm_stays: assert property (@(posedge clk_sys) disable iff (rst) (idle_cnt_q > 4'h8) |-> !$fell(shared_alarm_output_pin_oe))
    else $error("alarm pin released without a flag clear");
endmodule

bind rtc_spi_slave rtc_spi_slave_checker rtc_spi_slave_checker_i (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
  .so_oe(so_oe), .alarm_event(alarm_event),
  .shared_alarm_output_pin_out(shared_alarm_output_pin_out),
  .shared_alarm_output_pin_oe(shared_alarm_output_pin_oe));

// ---- test/spi_host_model.sv ----
// Behavioural serial bus controller that drives the link of the clock/calendar.
`timescale 1ns/1ps
module spi_host_model (
  // Serial link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic so_line;

  // A released data line shows the inverse of the output register, so no stale bit passes.
  assign so_line = so_oe ? so_out : ~so_out;

  // The clock rests low and select rests high outside frames.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic frame_begin();
    #20 cs_n = 1'b0;
    #20;
  endtask

  task automatic frame_end();
    #20 cs_n = 1'b1;
    #60;
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #15 sck = 1'b1;
      rx[i] = so_line;
      #15 sck = 1'b0;
    end
  endtask
endmodule

// ---- test/spi_rtc_command_interface_tb.sv ----
// Self-checking bench for the serial command interface of the clock/calendar.
`timescale 1ns/1ps
module spi_rtc_command_interface_tb
  import rtc_spi_pkg::*;
;
  typedef logic [7:0] frame_t [4];
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] alarm_event = 2'b00;
  logic sck;
  logic cs_n;
  logic si;
  logic so_out;
  logic so_oe;
  logic pin_out;
  logic pin_oe;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  // A short write cycle keeps the run brief; the busy polls below are sized for it.
  rtc_spi_slave #(.USER_NVM_BYTES(256), .WRITE_CYCLE_CLKS(400)) rtc_spi_slave_i (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe), .alarm_event(alarm_event),
    .shared_alarm_output_pin_out(pin_out), .shared_alarm_output_pin_oe(pin_oe));
  spi_host_model spi_host_model_i (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));

  // System clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input frame_t tx, input int n, output frame_t rx);
    spi_host_model_i.frame_begin();
    for (int i = 0; i < n; i++) begin
      spi_host_model_i.xfer(tx[i], rx[i]);
    end
    spi_host_model_i.frame_end();
  endtask

  task automatic send(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] d0,
      input logic [7:0] d1, input int n);
    frame_t rx;
    run('{op, ad, d0, d1}, n, rx);
  endtask

  task automatic rd2(input string what, input logic [7:0] op, input logic [7:0] ad,
      input logic [7:0] e0, input logic [7:0] e1);
    frame_t rx;
    run('{op, ad, 8'h00, 8'h00}, 4, rx);
    chk(what, e0, rx[2]);
    chk(what, e1, rx[3]);
  endtask

  task automatic stat(output logic [7:0] s);
    frame_t rx;
    run('{STATUS_READ_CMD, 8'h00, 8'h00, 8'h00}, 2, rx);
    s = rx[1];
  endtask

  // Busy must show at once and clear by itself while select keeps toggling for the polls.
  task automatic wait_idle();
    logic [7:0] s;
    stat(s);
    chk("status busy", 8'h05, s);
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++) begin
      stat(s);
    end
    chk("status idle", 8'h04, s);
  endtask

  task automatic t_latch();
    logic [7:0] s;
    stat(s);
    chk("status reset", 8'h00, s);
    send(WRITE_LATCH_SET_CMD, 8'h00, 8'h00, 8'h00, 1);
    stat(s);
    chk("latch set", STAT_WEL_MASK, s);
    send(WRITE_LATCH_CLEAR_CMD, 8'h00, 8'h00, 8'h00, 1);
    stat(s);
    chk("latch clear", 8'h00, s);
    send(STATUS_WRITE_CMD, 8'h04, 8'h00, 8'h00, 2);
    stat(s);
    chk("status locked", 8'h00, s);
    send(WRITE_LATCH_SET_CMD, 8'h00, 8'h00, 8'h00, 1);
    send(STATUS_WRITE_CMD, 8'h04, 8'h00, 8'h00, 2);
    stat(s);
    chk("status written", 8'h04, s);
  endtask

  // Writes straddle the clock-register top and the scratch top.
  task automatic t_clock_space();
    send(CLOCK_SPACE_WRITE_CMD, CLK_REG_LAST, 8'h3c, 8'h7e, 4);
    send(CLOCK_SPACE_WRITE_CMD, SRAM_LAST, 8'h99, 8'h11, 4);
    rd2("clock to sram", CLOCK_SPACE_READ_CMD, CLK_REG_LAST, 8'h3c, 8'h7e);
    rd2("sram top", CLOCK_SPACE_READ_CMD, SRAM_LAST, 8'h99, INVALID_READ);
    send(SCRATCH_MEMORY_CLEAR_CMD, 8'h00, 8'h00, 8'h00, 1);
    rd2("after clear", CLOCK_SPACE_READ_CMD, CLK_REG_LAST, 8'h3c, 8'h00);
    rd2("clear top", CLOCK_SPACE_READ_CMD, SRAM_LAST, 8'h00, INVALID_READ);
  endtask

  task automatic t_user();
    logic [7:0] s;
    send(USER_NVM_WRITE_CMD, 8'h10, 8'h11, 8'h00, 3);
    stat(s);
    chk("no cycle", 8'h04, s);
    rd2("user locked", USER_NVM_READ_CMD, 8'h10, NVM_ERASED, NVM_ERASED);
    send(WRITE_LATCH_SET_CMD, 8'h00, 8'h00, 8'h00, 1);
    send(USER_NVM_WRITE_CMD, 8'h10, 8'h5a, 8'h6b, 4);
    wait_idle();
    rd2("user data", USER_NVM_READ_CMD, 8'h10, 8'h5a, 8'h6b);
    // The top quarter is write protected since the status write; the bytes must be dropped.
    send(WRITE_LATCH_SET_CMD, 8'h00, 8'h00, 8'h00, 1);
    send(USER_NVM_WRITE_CMD, 8'hc0, 8'h12, 8'h34, 4);
    rd2("user protected", USER_NVM_READ_CMD, 8'hc0, NVM_ERASED, NVM_ERASED);
  endtask

  task automatic t_protected();
    logic [7:0] s;
    send(WRITE_LATCH_SET_CMD, 8'h00, 8'h00, 8'h00, 1);
    send(PROTECTED_NVM_WRITE_CMD, 8'h00, 8'h77, 8'h00, 3);
    stat(s);
    chk("no id cycle", 8'h00, {7'h00, s[0]});
    rd2("id locked", PROTECTED_NVM_READ_CMD, 8'h00, NVM_ERASED, NVM_ERASED);
    send(WRITE_LATCH_SET_CMD, 8'h00, 8'h00, 8'h00, 1);
    send(UNLOCK_STEP_CMD, UNLOCK_KEY_A, 8'h00, 8'h00, 2);
    send(UNLOCK_STEP_CMD, UNLOCK_KEY_B, 8'h00, 8'h00, 2);
    send(PROTECTED_NVM_WRITE_CMD, 8'h00, 8'h77, 8'h88, 4);
    wait_idle();
    rd2("id data", PROTECTED_NVM_READ_CMD, 8'h00, 8'h77, 8'h88);
    rd2("user apart", USER_NVM_READ_CMD, 8'h00, NVM_ERASED, NVM_ERASED);
  endtask

  task automatic t_alarm();
    logic [7:0] ad;
    // A low enable freezes the alarm flags, so a pulse during it leaves the pin alone.
    @(posedge clk_sys);
    #1 ce = 1'b0;
    alarm_event = 2'b01;
    @(posedge clk_sys);
    #1 alarm_event = 2'b00;
    repeat (3) @(posedge clk_sys);
    #1 ce = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("enable frozen", 8'h00, {7'h00, pin_oe});
    for (int k = 0; k < 2; k++) begin
      ad = (k == 0) ? ALM0_FLAG_ADDR : ALM1_FLAG_ADDR;
      @(posedge clk_sys);
      #1 alarm_event = (k == 0) ? 2'b01 : 2'b10;
      @(posedge clk_sys);
      #1 alarm_event = 2'b00;
      repeat (3) @(posedge clk_sys);
      chk("pin pulled", 8'h01, {7'h00, pin_oe});
      chk("pin level", 8'h00, {7'h00, pin_out});
      rd2("flag read", CLOCK_SPACE_READ_CMD, ad, ALM_FLAG_MASK, 8'h00);
      chk("pin held", 8'h01, {7'h00, pin_oe});
      send(CLOCK_SPACE_WRITE_CMD, ad, 8'h00, 8'h00, 3);
      repeat (8) @(posedge clk_sys);
      chk("pin released", 8'h00, {7'h00, pin_oe});
    end
  endtask

  // Reset for eight cycles, then each scenario in turn; select has stayed high throughout.
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("output idle", 8'h00, {7'h00, so_oe});
    t_latch();
    t_clock_space();
    t_user();
    t_protected();
    t_alarm();
    print_verdict();
  end
endmodule
